// file: common/field_access_pkg.sv
// Constants for the per-field access policy register bank.
// Assumes one clock domain and a synchronous active-low reset.
// Overview of operation
// (R1) Each field of a register carries its own access policy.
// (R2) Read-only fields return their value; writes leave them unchanged.
// (R3) Write-only fields accept writes; reads return a meaningless value.
// (R4) Read-write fields accept every write and return the last stored.
// (R5) Write-once fields take the first write after reset; reads undefined.
// (R6) Readable write-once fields read back; only first write taken.
// (R7) Reserved bits read as anything; here they read as zero.
// (R8) Host writes zero into reserved bits on every write.
// (R9) One written flag per write-once field, cleared only by reset.
`default_nettype none
package field_access_pkg;
    typedef enum logic [2:0] {
        POL_RESERVED = 3'h0,
        POL_RO = 3'h1,
        POL_WO = 3'h2,
        POL_RW = 3'h3,
        POL_WONCE = 3'h4,
        POL_RWONCE = 3'h5
    } policy_t;
    localparam int REG_COUNT = 4;
    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 2;
    localparam logic [7:0] UNDEF_READ_VALUE = 8'h00;
    localparam logic [7:0] STORE_RESET_VALUE = 8'h00;
endpackage
`default_nettype wire

// file: hdl/field_cell.sv
// One bit of a register with its own access policy.
// Assumes the caller gives one-cycle write strobes; reads are combinational.
`timescale 1ns/100ps
`default_nettype none
module field_cell
    import field_access_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Policy and live value
    input wire policy_t policy,
    input wire logic hw_value,
    // Access
    input wire logic wr_stb,
    input wire logic wr_bit,
    output logic store_bit,
    output logic read_bit,
    output logic written
);
    logic store_reg;
    logic written_reg;
    logic take;
    logic once_p;

    assign once_p = (policy == POL_WONCE) || (policy == POL_RWONCE);

    always_comb begin
        case (policy)
            POL_WO, POL_RW: take = wr_stb; // R3 R4
            POL_WONCE, POL_RWONCE: take = wr_stb && !written_reg; // R5 R6
            default: take = 1'b0; // R2
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            store_reg <= STORE_RESET_VALUE[0];
        end else if (take) begin
            store_reg <= wr_bit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            written_reg <= 1'b0;
        end else if (take && once_p) begin
            written_reg <= 1'b1; // R9
        end
    end

    always_comb begin
        case (policy)
            POL_RO: read_bit = hw_value; // R2
            POL_RW, POL_RWONCE: read_bit = store_reg; // R4 R6
            default: read_bit = UNDEF_READ_VALUE[0]; // R3 R5 R7
        endcase
    end

    assign store_bit = store_reg;
    assign written = written_reg;

    // First accepted write to a write-once bit
    sequence s_first_write;
        wr_stb && once_p && !written_reg;
    endsequence

    // Write to a bit that takes every write
    sequence s_plain_write;
        wr_stb && (policy == POL_WO || policy == POL_RW);
    endsequence

    chk_once_holds: assert property (@(posedge clk_sys) // R5
        disable iff (!rst_b)
        written_reg && once_p |=> $stable(store_reg))
        else $error("write-once field changed");
    chk_flag_sticky: assert property (@(posedge clk_sys) // R9
        disable iff (!rst_b)
        written_reg |=> written_reg)
        else $error("written flag dropped");
    chk_first_take: assert property (@(posedge clk_sys) // R5 R6 R9
        disable iff (!rst_b)
        s_first_write |=> written_reg && store_reg == $past(wr_bit))
        else $error("first write-once write not taken");
    chk_plain_take: assert property (@(posedge clk_sys) // R3 R4
        disable iff (!rst_b)
        s_plain_write |=> store_reg == $past(wr_bit))
        else $error("write to writable bit lost");
    chk_ro_discard: assert property (@(posedge clk_sys) // R2 R7
        disable iff (!rst_b)
        (policy == POL_RO || policy == POL_RESERVED)
        |=> $stable(store_reg))
        else $error("write reached a read-only bit");
endmodule
`default_nettype wire

// file: hdl/field_access_bank.sv
// Register bank enforcing per-field access policies.
// Assumes the link front end gives one-cycle read and write requests.
`timescale 1ns/100ps
`default_nettype none
module field_access_bank
    import field_access_pkg::*;
#(
    parameter int NREG = REG_COUNT,
    parameter int AW = ADDR_WIDTH,
    parameter policy_t [REG_COUNT*REG_WIDTH-1:0] POLICY = '{default: POL_RW}
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Write request
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [REG_WIDTH-1:0] wr_data,
    // Read request
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [REG_WIDTH-1:0] rd_data,
    output logic rd_valid,
    // Hardware status for read-only bits
    input wire logic [NREG*REG_WIDTH-1:0] hw_status,
    // Stored field contents and write-once flags
    output logic [NREG*REG_WIDTH-1:0] field_out,
    output logic [NREG*REG_WIDTH-1:0] written_out
);
    // Sizes that the decode and the policy vector can serve
    if (NREG != REG_COUNT) begin : g_bad_count
        $error("field_access_bank: policy vector sized for REG_COUNT");
    end
    if (AW < 1 || AW > 16) begin : g_bad_width
        $error("field_access_bank: address width out of range");
    end
    if ((1 << AW) < NREG) begin : g_bad_span
        $error("field_access_bank: address too narrow for NREG");
    end

    logic [NREG*REG_WIDTH-1:0] store_w;
    logic [NREG*REG_WIDTH-1:0] read_w;
    logic [NREG*REG_WIDTH-1:0] written_w;
    logic [REG_WIDTH-1:0] rd_data_reg;
    logic rd_valid_reg;
    logic [NREG*REG_WIDTH-1:0] field_reg;
    logic [NREG*REG_WIDTH-1:0] written_reg;
    logic [NREG-1:0] wr_sel;
    logic [REG_WIDTH-1:0] rd_mux;
    logic rd_mapped;

    // Register select, shared by the write and read decoders
    function automatic logic hit(input logic [AW-1:0] a, input int r);
        hit = (a == r[AW-1:0]);
    endfunction

    // Policies that keep a written flag
    function automatic logic once_policy(input policy_t p);
        once_policy = (p == POL_WONCE) || (p == POL_RWONCE);
    endfunction

    // Policies that read back the stored bit
    function automatic logic stored_policy(input policy_t p);
        stored_policy = (p == POL_RW) || (p == POL_RWONCE);
    endfunction

    // Policies whose reads carry no meaning
    function automatic logic undef_policy(input policy_t p);
        undef_policy = (p == POL_WO) || (p == POL_WONCE) ||
            (p == POL_RESERVED);
    endfunction

    // One write strobe per register
    always_comb begin
        wr_sel = '0;
        for (int r = 0; r < NREG; r++) begin
            if (wr_en && hit(wr_addr, r)) begin
                wr_sel[r] = 1'b1;
            end
        end
    end

    // Read mux; an address past the last register reads as undefined
    always_comb begin
        rd_mux = UNDEF_READ_VALUE;
        rd_mapped = 1'b0;
        for (int r = 0; r < NREG; r++) begin
            if (hit(rd_addr, r)) begin
                rd_mux = read_w[r*REG_WIDTH +: REG_WIDTH];
                rd_mapped = 1'b1;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NREG*REG_WIDTH; g++) begin : g_bit
            field_cell u_cell (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .policy(POLICY[g]), // R1
                .hw_value(hw_status[g]),
                .wr_stb(wr_sel[g / REG_WIDTH]),
                .wr_bit(wr_data[g % REG_WIDTH]),
                .store_bit(store_w[g]),
                .read_bit(read_w[g]),
                .written(written_w[g])
            );

            // Per-bit checks, chosen by the bit's policy
            if (POLICY[g] > POL_RWONCE) begin : g_bad_code
                $error("field_access_bank: unknown policy code");
            end
            if (POLICY[g] == POL_RO) begin : g_chk_ro
                chk_ro_live: assert property (@(posedge clk_sys) // R2
                    disable iff (!rst_b)
                    rd_en && hit(rd_addr, g / REG_WIDTH)
                    |=> rd_data[g % REG_WIDTH] == $past(hw_status[g]))
                    else $error("read-only bit misread");
                chk_ro_untouched: assert property (@(posedge clk_sys) // R2
                    disable iff (!rst_b)
                    field_out[g] == STORE_RESET_VALUE[0])
                    else $error("read-only bit was written");
            end else if (POLICY[g] == POL_RW) begin : g_chk_rw
                chk_rw_mirror: assert property (@(posedge clk_sys) // R1 R4
                    disable iff (!rst_b)
                    wr_sel[g / REG_WIDTH]
                    |=> ##1 field_out[g] == $past(wr_data[g % REG_WIDTH], 2))
                    else $error("read-write bit not stored");
            end else if (once_policy(POLICY[g])) begin : g_chk_once
                chk_once_frozen: assert property (@(posedge clk_sys) // R5 R6
                    disable iff (!rst_b)
                    written_out[g] |=> $stable(field_out[g]))
                    else $error("write-once bit changed after its write");
                chk_flag_cause: assert property (@(posedge clk_sys) // R9
                    disable iff (!rst_b)
                    $rose(written_out[g]) |-> $past(wr_sel[g / REG_WIDTH], 2))
                    else $error("written flag rose without a write");
            end
            if (stored_policy(POLICY[g])) begin : g_chk_stored
                chk_read_stored: assert property (@(posedge clk_sys) // R4 R6
                    disable iff (!rst_b)
                    rd_en && hit(rd_addr, g / REG_WIDTH)
                    |=> rd_data[g % REG_WIDTH] == $past(store_w[g]))
                    else $error("readable bit misread");
            end
            if (undef_policy(POLICY[g])) begin : g_chk_undef
                chk_read_undef: assert property (@(posedge clk_sys) // R3 R5 R7
                    disable iff (!rst_b)
                    rd_en && hit(rd_addr, g / REG_WIDTH)
                    |=> rd_data[g % REG_WIDTH] == UNDEF_READ_VALUE[0])
                    else $error("unreadable bit not at its fixed value");
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_data_reg <= UNDEF_READ_VALUE;
        end else if (rd_en) begin
            if (rd_mapped) begin
                rd_data_reg <= rd_mux; // R1
            end else begin
                rd_data_reg <= UNDEF_READ_VALUE; // R7
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_valid_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_en;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            field_reg <= '0;
            written_reg <= '0;
        end else begin
            field_reg <= store_w;
            written_reg <= written_w;
        end
    end

    assign rd_data = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign field_out = field_reg;
    assign written_out = written_reg;

    // Read handshake: a request, then a one-cycle answer
    sequence s_read_req;
        rd_en;
    endsequence

    sequence s_read_idle;
        !rd_en;
    endsequence

    sequence s_read_answer;
        rd_valid;
    endsequence

    chk_read_latency: assert property (@(posedge clk_sys) // R4
        disable iff (!rst_b)
        s_read_req |=> s_read_answer)
        else $error("read answer late");
    chk_no_spurious: assert property (@(posedge clk_sys) // R4
        disable iff (!rst_b)
        s_read_idle |=> !rd_valid)
        else $error("spurious read valid");
    chk_data_holds: assert property (@(posedge clk_sys) // R4
        disable iff (!rst_b)
        s_read_idle |=> $stable(rd_data))
        else $error("read data moved without a read");

    // Reset leaves no answer and no written flag behind
    chk_reset_clears: assert property (@(posedge clk_sys) // R9
        !rst_b |=> !rd_valid && written_out == '0)
        else $error("outputs not cleared by reset");
endmodule
`default_nettype wire

// file: tb/host_model.sv
// Host side issuing register writes and reads.
// Assumes requests are taken on the rising edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input wire logic clk_sys,
    // Requests
    output logic wr_en,
    output logic [1:0] wr_addr,
    output logic [7:0] wr_data,
    output logic rd_en,
    output logic [1:0] rd_addr,
    // Answer
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    initial begin
        {wr_en, wr_addr, wr_data, rd_en, rd_addr} = '0;
    end
    task automatic put(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        wr_en = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk_sys);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
    task automatic get(input logic [1:0] a, output logic [7:0] d);
        @(negedge clk_sys);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge clk_sys);
        rd_en = 1'b0;
        d = rd_valid ? rd_data : 8'hXX;
    endtask
endmodule
`default_nettype wire

// file: tb/field_access_bank_test.sv
// Bench for the per-field access policy bank.
// Assumes the host model above drives the request ports.
`timescale 1ns/100ps
`default_nettype none
module field_access_bank_test import field_access_pkg::*;;
    function automatic policy_t [31:0] pols();
        for (int g = 0; g < 32; g++) begin
            if (g < 8) begin
                pols[g] = POL_RO;
            end else if (g < 16) begin
                pols[g] = POL_WO;
            end else if (g < 24) begin
                pols[g] = POL_WONCE;
            end else if (g < 28) begin
                pols[g] = POL_RWONCE;
            end else if (g < 30) begin
                pols[g] = POL_RW;
            end else begin
                pols[g] = POL_RESERVED;
            end
        end
    endfunction
    logic clk_sys = 0, rst_b = 0, wr_en, rd_en, rd_valid;
    logic [1:0] wr_addr, rd_addr;
    logic [7:0] wr_data, rd_data, d;
    logic [31:0] hw_status = 32'h5A, field_out, written_out;
    int n_errors = 0, n_tests = 0, cyc = 0;
    field_access_bank #(.POLICY(pols())) u_dut (.clk_sys, .rst_b,
        .wr_en, .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data,
        .rd_valid, .hw_status, .field_out, .written_out);
    host_model u_host (.clk_sys, .wr_en, .wr_addr, .wr_data, .rd_en,
        .rd_addr, .rd_data, .rd_valid);
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic check(string s, logic [7:0] got, logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", s, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic t_ro();
        u_host.put(2'h0, 8'hFF);
        u_host.get(2'h0, d);
        check("ro", d, 8'h5A);
        check("ro kept", field_out[7:0], STORE_RESET_VALUE);
        @(negedge clk_sys);
        hw_status[7:0] = 8'hC3;
        u_host.get(2'h0, d);
        check("ro live", d, 8'hC3);
        $display("test ro done");
    endtask
    task automatic t_wo();
        u_host.put(2'h1, 8'hA5);
        repeat (2) @(negedge clk_sys);
        check("wo", field_out[15:8], 8'hA5);
        u_host.get(2'h1, d);
        check("wo read", d, UNDEF_READ_VALUE);
        $display("test wo done");
    endtask
    task automatic t_once();
        u_host.put(2'h2, 8'h3C);
        u_host.put(2'h2, 8'hC3);
        repeat (2) @(negedge clk_sys);
        check("once", field_out[23:16], 8'h3C);
        check("flag", written_out[23:16], 8'hFF);
        u_host.get(2'h2, d);
        check("once read", d, UNDEF_READ_VALUE);
        $display("test once done");
    endtask
    task automatic t_mix();
        u_host.put(2'h3, 8'h15);
        u_host.get(2'h3, d);
        check("mix1", d & 8'h3F, 8'h15);
        u_host.put(2'h3, 8'h3A);
        u_host.get(2'h3, d);
        check("mix2", d & 8'h3F, 8'h35);
        check("rsv", d & 8'hC0, 8'h00);
        check("mix flag", written_out[31:24], 8'h0F);
        $display("test mix done");
    endtask
    task automatic t_rst();
        @(negedge clk_sys);
        rst_b = 0;
        @(negedge clk_sys);
        rst_b = 1;
        check("clr", written_out[23:16], 8'h00);
        u_host.put(2'h2, 8'h81);
        repeat (2) @(negedge clk_sys);
        check("again", field_out[23:16], 8'h81);
        $display("test reset done");
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(negedge clk_sys);
        rst_b = 1;
        t_ro();
        t_wo();
        t_once();
        t_mix();
        t_rst();
        test_done();
    end
endmodule
`default_nettype wire
